//--- common/thr_pkg.sv
/*
 * Shared constants and types for the threshold relay and peak hold supervisor.
 * Assumes a single 10 MHz system clock; all times are derived from it here.
 */
`default_nettype none
package thr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Data widths
	localparam int DW = 16;     // Measured value and thresholds, two's complement
	localparam int EW = 18;     // Guard width for border sums and differences
	localparam logic [DW-1:0] VAL_ZERO = 16'h0000; // Cleared value
	localparam logic [DW-1:0] DLY_NONE = 16'h0000; // Delay or time of zero

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_NS = 100;          // System clock period
	localparam int unsigned TICK_MS = 100;         // Base tick, 0.1 s
	localparam int unsigned TICK_NS = TICK_MS * 1000000;
	localparam int unsigned TICK_CYC = TICK_NS / CLK_NS; // Cycles per tick
	localparam int unsigned QUICK_MS = 5000;       // Quick view timeout
	localparam int unsigned QUICK_TICKS = QUICK_MS / TICK_MS;
	localparam int unsigned ID_MS = 2000;          // Start-up banner time
	localparam int unsigned ID_TICKS = ID_MS / TICK_MS;
	localparam int unsigned BLINK_MS = 500;        // Half period of flashing
	localparam int unsigned BLINK_TICKS = BLINK_MS / TICK_MS;
	localparam int unsigned TICKS_PER_SEC = 1000 / TICK_MS;
	localparam int unsigned SEC_PER_MIN = 60;

	// Counter widths
	localparam int TICK_W = 24;
	localparam int SEC_W = 4;
	localparam int MIN_W = 6;
	localparam int BL_W = 3;
	localparam int ID_W = 5;
	localparam int Q_W = 6;

	////////////////////////////////////////////////////////////////////////////
	// Key positions inside the synchronised key vector
	localparam int KEY_N = 4;
	localparam int KEY_UP = 0;
	localparam int KEY_DN = 1;
	localparam int KEY_ENT = 2;
	localparam int KEY_ESC = 3;

	////////////////////////////////////////////////////////////////////////////
	// Enumerations
	typedef enum logic [1:0]
	{
		ST_ID = 2'h0,    // Banner after power-up
		ST_MEAS = 2'h1,  // Measurement display
		ST_QUICK = 2'h3  // Threshold quick view
	} thr_st_t;

	typedef enum logic [2:0]
	{
		DISP_ID = 3'h0,    // Identification and firmware version
		DISP_VALUE = 3'h1, // Live measured value
		DISP_OVER = 3'h2,  // over_range_warning
		DISP_UNDER = 3'h3, // under_range_warning
		DISP_PEAK = 3'h4,  // Held peak value
		DISP_QNAME = 3'h5, // Threshold name in quick view
		DISP_QVAL = 3'h6   // Threshold value in quick view
	} thr_disp_t;

	typedef enum logic [1:0]
	{
		OUT_UNUSED = 2'h0, // Output never on
		OUT_ONE = 2'h1,    // One threshold control
		OUT_TWO = 2'h2     // Two threshold control
	} thr_omode_t;

	typedef enum logic [1:0]
	{
		CRIT_HOLD = 2'h0, // Leave output as it is
		CRIT_ON = 2'h1,   // Force output on
		CRIT_OFF = 2'h2   // Force output off
	} thr_crit_t;

endpackage : thr_pkg
`default_nettype wire

//--- rtl/thr_dly.sv
/*
 * On-delay and off-delay qualifier for one output.
 * Assumes want_i is a level from the same clock domain and unit_tick_i a
 * one-cycle pulse per delay unit.
 */
`timescale 1ns/1ps
`default_nettype none
module thr_dly
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Request and time base
	input wire logic want_i,
	input wire logic unit_tick_i,
	// Delays in units
	input wire logic [thr_pkg::DW-1:0] on_dly_i,
	input wire logic [thr_pkg::DW-1:0] off_dly_i,
	// Qualified state
	output logic state_o
);
	import thr_pkg::*;

	// Whole state of the qualifier
	typedef struct packed
	{
		logic on;          // Present qualified state
		logic [DW-1:0] cnt; // Units spent beyond the border
	} thr_dly_t;

	localparam thr_dly_t DLY_RST = '0; // Off, nothing counted

	thr_dly_t state_ff;
	thr_dly_t nxt_state;
	logic [DW-1:0] need; // Delay that applies to the pending change

	////////////////////////////////////////////////////////////////////////////
	// Next state
	// The first unit may be partly elapsed at the crossing, so the real wait is
	// up to one unit shorter than set; finer timing would cost a wider counter.
	always_comb
	begin
		nxt_state = state_ff;
		need = want_i ? on_dly_i : off_dly_i;
		if (want_i == state_ff.on)
		begin
			// Input went back across the border: restart timing
			nxt_state.cnt = VAL_ZERO;
		end
		else if (need == DLY_NONE)
		begin
			// No delay: follow the crossing at once
			nxt_state.on = want_i;
		end
		else if (unit_tick_i)
		begin
			if (state_ff.cnt + 1'b1 >= need)
			begin
				// Stayed beyond the border for the whole delay
				nxt_state.on = want_i;
				nxt_state.cnt = VAL_ZERO;
			end
			else
			begin
				nxt_state.cnt = state_ff.cnt + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= DLY_RST;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign state_o = state_ff.on;

endmodule : thr_dly
`default_nettype wire

//--- rtl/thr_top.sv
/*
 * Measurement-mode supervisor: display selection, peak detection with timed
 * hold, threshold quick view, and relay/LED control with hysteresis, delays
 * and critical-state override.
 * Assumes measured value and range flags come from logic on sys_clk_i;
 * keys come from pins and are synchronised here. Settings are static levels.
 */
`timescale 1ns/1ps
`default_nettype none
module thr_top
#(
	parameter int unsigned TICK_CYC = thr_pkg::TICK_CYC, // Cycles per 0.1 s
	parameter logic [thr_pkg::DW-1:0] FW_ID = 16'h0001   // Arbitrary value
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Measured value from the front end
	input wire logic [thr_pkg::DW-1:0] meas_i,
	input wire logic over_range_i,
	input wire logic under_range_i,
	// Front keys, raw pins
	input wire logic key_up_i,
	input wire logic key_dn_i,
	input wire logic key_ent_i,
	input wire logic key_esc_i,
	// Output control settings
	input wire thr_pkg::thr_omode_t out_mode_i,
	input wire logic act_i,
	input wire logic [thr_pkg::DW-1:0] first_threshold_i,
	input wire logic [thr_pkg::DW-1:0] second_threshold_i,
	input wire logic [thr_pkg::DW-1:0] hysteresis_width_i,
	input wire logic [thr_pkg::DW-1:0] on_delay_i,
	input wire logic [thr_pkg::DW-1:0] off_delay_i,
	input wire logic unit_min_i,
	input wire thr_pkg::thr_crit_t critical_state_action_i,
	input wire logic relay_fit_i,
	// Peak settings
	input wire logic [thr_pkg::DW-1:0] min_peak_swing_i,
	input wire logic [thr_pkg::DW-1:0] peak_time_i,
	input wire logic hold_zero_i,
	input wire logic src_peak_i,
	input wire logic free_access_i,
	// Display
	output var thr_pkg::thr_disp_t disp_sel_o,
	output logic [thr_pkg::DW-1:0] disp_val_o,
	output logic dp_flash_o,
	// Outputs
	output logic relay_o,
	output logic led_o,
	// Quick edit request
	output logic edit_req_o,
	output logic edit_idx_o
);
	import thr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed
	{
		thr_st_t st;              // Display mode
		logic [TICK_W-1:0] tick_cnt; // Cycles into the 0.1 s tick
		logic [SEC_W-1:0] sec_cnt;   // Ticks into the second
		logic [MIN_W-1:0] min_cnt;   // Seconds into the minute
		logic [BL_W-1:0] blink_cnt;  // Ticks into the blink half period
		logic blink;                 // Flash phase
		logic [ID_W-1:0] id_cnt;     // Banner ticks
		logic q_idx;                 // Threshold shown in quick view
		logic [Q_W-1:0] q_cnt;       // Quick view idle ticks
		logic [KEY_N-1:0] ks1;       // Key synchroniser, first stage
		logic [KEY_N-1:0] ks2;       // Key synchroniser, second stage
		logic [KEY_N-1:0] kprev;     // Keys one cycle earlier
		logic [DW-1:0] run_min;      // Valley before the running extreme
		logic [DW-1:0] run_max;      // Running extreme
		logic [DW-1:0] pk_val;       // Last confirmed peak
		logic pk_show;               // Peak is being displayed
		logic [DW-1:0] pk_cnt;       // Peak display ticks
		logic zone_a;                // Comparison value in zone A
		logic led;                   // Output state
		logic rly;                   // Relay drive
		logic edit_req;              // Edit request pulse
		logic edit_idx;              // Threshold to edit
		thr_disp_t disp_sel;         // What the display shows
		logic [DW-1:0] disp_val;     // Number behind it
		logic dp;                    // Rightmost decimal point
	} thr_state_t;

	// All zero is ST_ID and DISP_ID with every counter cleared
	localparam thr_state_t THR_RST = '0;

	thr_state_t state_ff;
	thr_state_t nxt_state;

	// Time base pulses
	logic tick;
	logic sec_tick;
	logic min_tick;
	logic unit_tick;
	// Key presses
	logic [KEY_N-1:0] press;
	logic step_key;
	// Peak arithmetic
	logic signed [EW-1:0] m_x;
	logic signed [EW-1:0] rise;
	logic signed [EW-1:0] fall;
	logic signed [EW-1:0] swing;
	logic pk_evt;
	// Comparison arithmetic
	logic signed [EW-1:0] cmp;
	logic signed [EW-1:0] t_lo;
	logic signed [EW-1:0] t_hi;
	logic signed [EW-1:0] hy;
	logic want;
	logic dly_on;
	logic crit;
	logic fin;

	// Sign extension to the guard width
	function automatic logic signed [EW-1:0] sx(input logic [DW-1:0] v);
		sx = $signed({{(EW-DW){v[DW-1]}}, v});
	endfunction : sx

	// Zero extension to the guard width
	function automatic logic signed [EW-1:0] ux(input logic [DW-1:0] v);
		ux = $signed({{(EW-DW){1'b0}}, v});
	endfunction : ux

	////////////////////////////////////////////////////////////////////////////
	// Delay qualifier; its time base comes from the shared tick chain
	thr_dly u_dly
	(
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.want_i(want),
		.unit_tick_i(unit_tick),
		.on_dly_i(on_delay_i),
		.off_dly_i(off_delay_i),
		.state_o(dly_on)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.edit_req = 1'b0;

		// Tick chain: 0.1 s, seconds, minutes
		tick = (state_ff.tick_cnt == TICK_W'(TICK_CYC - 1));
		nxt_state.tick_cnt = tick ? '0 : state_ff.tick_cnt + 1'b1;
		sec_tick = tick && (state_ff.sec_cnt == SEC_W'(TICKS_PER_SEC - 1));
		min_tick = sec_tick && (state_ff.min_cnt == MIN_W'(SEC_PER_MIN - 1));
		if (tick)
		begin
			nxt_state.sec_cnt = sec_tick ? '0 : state_ff.sec_cnt + 1'b1;
		end
		if (sec_tick)
		begin
			nxt_state.min_cnt = min_tick ? '0 : state_ff.min_cnt + 1'b1;
		end
		unit_tick = unit_min_i ? min_tick : sec_tick;

		// Flash phase shared by quick view and peak point
		if (tick)
		begin
			if (state_ff.blink_cnt == BL_W'(BLINK_TICKS - 1))
			begin
				nxt_state.blink_cnt = '0;
				nxt_state.blink = ~state_ff.blink;
			end
			else
			begin
				nxt_state.blink_cnt = state_ff.blink_cnt + 1'b1;
			end
		end

		// Keys: two flops from the pins, then a rising-edge detector
		nxt_state.ks1 = {key_esc_i, key_ent_i, key_dn_i, key_up_i};
		nxt_state.ks2 = state_ff.ks1;
		nxt_state.kprev = state_ff.ks2;
		press = state_ff.ks2 & ~state_ff.kprev;
		step_key = press[KEY_UP] | press[KEY_DN];

		//////////////////////////////////////////////////////////////////////
		// Peak detection: valley, then extreme, then swing back
		m_x = sx(meas_i);
		swing = ux(min_peak_swing_i);
		rise = sx(state_ff.run_max) - sx(state_ff.run_min);
		fall = sx(state_ff.run_max) - m_x;
		pk_evt = 1'b0;
		if (rise >= swing && fall >= swing)
		begin
			// Confirmed: rose and fell back by the swing
			pk_evt = 1'b1;
			nxt_state.run_min = meas_i;
			nxt_state.run_max = meas_i;
		end
		else if (m_x < sx(state_ff.run_min))
		begin
			// New valley restarts the climb
			nxt_state.run_min = meas_i;
			nxt_state.run_max = meas_i;
		end
		else if (m_x > sx(state_ff.run_max))
		begin
			nxt_state.run_max = meas_i;
		end

		// Peak hold timer in 0.1 s ticks
		if (pk_evt)
		begin
			nxt_state.pk_val = state_ff.run_max;
			if (peak_time_i != DLY_NONE || hold_zero_i)
			begin
				// Newer peak replaces the shown one and restarts time
				nxt_state.pk_show = 1'b1;
				nxt_state.pk_cnt = VAL_ZERO;
			end
		end
		else if (state_ff.pk_show && press[KEY_ESC])
		begin
			nxt_state.pk_show = 1'b0;
		end
		else if (state_ff.pk_show && peak_time_i == DLY_NONE && !hold_zero_i)
		begin
			// Zero without hold means nothing is held
			nxt_state.pk_show = 1'b0;
		end
		else if (state_ff.pk_show && tick && peak_time_i != DLY_NONE)
		begin
			if (state_ff.pk_cnt + 1'b1 >= peak_time_i)
			begin
				nxt_state.pk_show = 1'b0;
			end
			else
			begin
				nxt_state.pk_cnt = state_ff.pk_cnt + 1'b1;
			end
		end

		//////////////////////////////////////////////////////////////////////
		// Zone tracking with hysteresis; runs in every display mode so that
		// configuration never pauses control
		cmp = src_peak_i ? sx(state_ff.pk_val) : m_x;
		hy = ux(hysteresis_width_i);
		// Order-free pair of thresholds
		if (sx(first_threshold_i) < sx(second_threshold_i))
		begin
			t_lo = sx(first_threshold_i);
			t_hi = sx(second_threshold_i);
		end
		else
		begin
			t_lo = sx(second_threshold_i);
			t_hi = sx(first_threshold_i);
		end
		if (out_mode_i == OUT_TWO)
		begin
			// Zone A is between the thresholds, past the inner borders
			if (cmp > t_lo + hy && cmp < t_hi - hy)
			begin
				nxt_state.zone_a = 1'b1;
			end
			else if (cmp < t_lo - hy || cmp > t_hi + hy)
			begin
				nxt_state.zone_a = 1'b0;
			end
		end
		else
		begin
			// Zone A lies above the first threshold
			if (cmp > sx(first_threshold_i) + hy)
			begin
				nxt_state.zone_a = 1'b1;
			end
			else if (cmp < sx(first_threshold_i) - hy)
			begin
				nxt_state.zone_a = 1'b0;
			end
		end
		// Action bit: on in zone A (one) or inside (two), else the opposite
		want = (state_ff.zone_a == act_i);

		// Output selection and critical override
		crit = over_range_i | under_range_i;
		unique case (out_mode_i)
			OUT_UNUSED: fin = 1'b0;
			OUT_ONE: fin = dly_on;
			OUT_TWO: fin = dly_on;
			default: fin = 1'b0;
		endcase
		if (crit && out_mode_i != OUT_UNUSED)
		begin
			unique case (critical_state_action_i)
				CRIT_ON: fin = 1'b1;
				CRIT_OFF: fin = 1'b0;
				CRIT_HOLD: fin = state_ff.led;
				default: fin = state_ff.led;
			endcase
		end
		nxt_state.led = fin;
		nxt_state.rly = fin & relay_fit_i;

		//////////////////////////////////////////////////////////////////////
		// Display mode
		unique case (state_ff.st)
			ST_ID:
			begin
				// Banner, then measurement with no key needed
				if (tick)
				begin
					nxt_state.id_cnt = state_ff.id_cnt + 1'b1;
					if (state_ff.id_cnt == ID_W'(ID_TICKS - 1))
					begin
						nxt_state.st = ST_MEAS;
					end
				end
			end
			ST_MEAS:
			begin
				if (step_key)
				begin
					nxt_state.st = ST_QUICK;
					nxt_state.q_idx = 1'b0;
					nxt_state.q_cnt = '0;
				end
			end
			ST_QUICK:
			begin
				if (step_key)
				begin
					// Next threshold; only the first exists unless two are used
					nxt_state.q_idx = (out_mode_i == OUT_TWO) ? ~state_ff.q_idx : 1'b0;
					nxt_state.q_cnt = '0;
				end
				else if (press[KEY_ENT] && free_access_i)
				begin
					nxt_state.edit_req = 1'b1;
					nxt_state.edit_idx = state_ff.q_idx;
				end
				else if (press[KEY_ESC])
				begin
					nxt_state.st = ST_MEAS;
				end
				else if (tick)
				begin
					if (state_ff.q_cnt == Q_W'(QUICK_TICKS - 1))
					begin
						nxt_state.st = ST_MEAS;
					end
					else
					begin
						nxt_state.q_cnt = state_ff.q_cnt + 1'b1;
					end
				end
			end
			default:
			begin
				nxt_state.st = ST_MEAS;
			end
		endcase

		// Display contents, registered
		nxt_state.dp = 1'b0;
		unique case (state_ff.st)
			ST_ID:
			begin
				nxt_state.disp_sel = DISP_ID;
				nxt_state.disp_val = FW_ID;
			end
			ST_QUICK:
			begin
				// Name and value alternate on the flash phase
				nxt_state.disp_sel = state_ff.blink ? DISP_QNAME : DISP_QVAL;
				nxt_state.disp_val = state_ff.q_idx ? second_threshold_i : first_threshold_i;
			end
			default:
			begin
				nxt_state.disp_val = meas_i;
				if (over_range_i)
				begin
					nxt_state.disp_sel = DISP_OVER;
				end
				else if (under_range_i)
				begin
					nxt_state.disp_sel = DISP_UNDER;
				end
				else if (state_ff.pk_show)
				begin
					nxt_state.disp_sel = DISP_PEAK;
					nxt_state.disp_val = state_ff.pk_val;
					nxt_state.dp = state_ff.blink;
				end
				else
				begin
					nxt_state.disp_sel = DISP_VALUE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= THR_RST;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	assign disp_sel_o = state_ff.disp_sel;
	assign disp_val_o = state_ff.disp_val;
	assign dp_flash_o = state_ff.dp;
	assign relay_o = state_ff.rly;
	assign led_o = state_ff.led;
	assign edit_req_o = state_ff.edit_req;
	assign edit_idx_o = state_ff.edit_idx;

endmodule : thr_top
`default_nettype wire

//--- verification/thr_src.sv
/*
 * Front end model: hands the commanded value on, inverted when out of range, and flags range faults.
 * Assumes val_i changes just after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module thr_src
#(
	parameter logic signed [15:0] HI_LIM = 16'sh03e8, // Top of valid range
	parameter logic signed [15:0] LO_LIM = -16'sh01f4 // Bottom of valid range
)
(
	// Commanded value
	input wire logic [thr_pkg::DW-1:0] val_i,
	// Toward the supervisor
	output logic [thr_pkg::DW-1:0] meas_o,
	output logic over_range_o,
	output logic under_range_o
);
	import thr_pkg::*;
	////////////////////////////////////////
	// A faulted reading is junk, so it is inverted to keep it from looking valid
	always_comb
	begin
		over_range_o = $signed(val_i) > HI_LIM;
		under_range_o = $signed(val_i) < LO_LIM;
		meas_o = (over_range_o || under_range_o) ? ~val_i : val_i;
	end
endmodule : thr_src
`default_nettype wire

//--- verification/thr_chk.sv
/*
 * Port checker for the supervisor.
 * Assumes it is bound to every thr_top instance.
 */
`timescale 1ns/1ps
`default_nettype none
module thr_chk
(
	// Watched ports
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [thr_pkg::DW-1:0] meas_i,
	input wire logic over_range_i,
	input wire logic under_range_i,
	input wire thr_pkg::thr_omode_t out_mode_i,
	input wire thr_pkg::thr_crit_t critical_state_action_i,
	input wire logic [thr_pkg::DW-1:0] off_delay_i,
	input wire logic relay_fit_i,
	input wire logic free_access_i,
	input wire thr_pkg::thr_disp_t disp_sel_o,
	input wire logic [thr_pkg::DW-1:0] disp_val_o,
	input wire logic dp_flash_o,
	input wire logic relay_o,
	input wire logic led_o,
	input wire logic edit_req_o
);
	import thr_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Critical input while an output mode is active
	wire logic crit_w = (over_range_i || under_range_i) && (out_mode_i == OUT_ONE || out_mode_i == OUT_TWO);
	////////////////////////////////////////
	// Banner holds after reset
	id_start_a: assert property ($rose(rst_n_i) |-> disp_sel_o == DISP_ID [*8])
		else $error("banner not shown");
	range_over_a: assert property ($past(over_range_i) && disp_sel_o inside {DISP_VALUE, DISP_UNDER, DISP_PEAK}
		|-> 1'b0) else $error("over range not shown");
	range_under_a: assert property ($past(under_range_i && !over_range_i) && disp_sel_o inside {DISP_VALUE, DISP_PEAK}
		|-> 1'b0) else $error("under range not shown");
	value_show_a: assert property (disp_sel_o == DISP_VALUE |-> disp_val_o == $past(meas_i))
		else $error("wrong live value");
	edit_pulse_a: assert property (edit_req_o |-> $past(free_access_i) ##1 !edit_req_o)
		else $error("bad edit pulse");
	flash_peak_a: assert property (dp_flash_o |-> disp_sel_o == DISP_PEAK)
		else $error("flash without peak");
	relay_led_a: assert property (relay_o == (led_o && $past(relay_fit_i)))
		else $error("relay differs from led");
	unused_off_a: assert property ((out_mode_i == OUT_UNUSED && off_delay_i == DLY_NONE) [*3] |-> !led_o)
		else $error("unused output on");
	crit_on_a: assert property ((crit_w && critical_state_action_i == CRIT_ON) [*2] |-> led_o)
		else $error("critical on ignored");
	crit_off_a: assert property ((crit_w && critical_state_action_i == CRIT_OFF) [*2] |-> !led_o)
		else $error("critical off ignored");
	crit_hold_a: assert property ((crit_w && critical_state_action_i == CRIT_HOLD) [*2] |-> $stable(led_o))
		else $error("critical hold moved");
	// Main scenarios reached
	cover property (edit_req_o);
	cover property (disp_sel_o == DISP_PEAK && dp_flash_o);
	cover property ($rose(led_o));
endmodule : thr_chk
bind thr_top thr_chk u_chk (.sys_clk_i, .rst_n_i, .meas_i, .over_range_i, .under_range_i, .out_mode_i,
	.critical_state_action_i, .off_delay_i, .relay_fit_i, .free_access_i, .disp_sel_o, .disp_val_o,
	.dp_flash_o, .relay_o, .led_o, .edit_req_o);
`default_nettype wire

//--- verification/test_threshold_relay_peak_hold.sv
/*
 * Self-checking bench for the supervisor.
 * Assumes thr_src feeds the measured value and a 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module test_threshold_relay_peak_hold;
	import thr_pkg::*;
	localparam logic signed [15:0] HI_LIM = 16'sh03e8; // Range limits of the model
	localparam logic signed [15:0] LO_LIM = -16'sh01f4;
	localparam logic [15:0] FW = 16'h00a5; // Arbitrary value
	typedef struct packed {thr_omode_t m; logic a; thr_crit_t c; logic [15:0] t2; logic [15:0] v; logic f; logic led;} thr_row_t;
	// Stimulus, threshold 100, hysteresis 10
	logic sys_clk_i, rst_n_i = 1'b0, act_i = 1'b1, relay_fit_i = 1'b1, hold_zero_i = 1'b0;
	logic src_peak_i = 1'b0, free_access_i = 1'b1, unit_min_i = 1'b0;
	logic [3:0] keys = 4'h0;
	logic [15:0] val = 16'h0050, first_threshold_i = 16'h0064, second_threshold_i = 16'h0000;
	logic [15:0] hysteresis_width_i = 16'h000a, on_delay_i = 16'h0000, off_delay_i = 16'h0000;
	logic [15:0] min_peak_swing_i = 16'h0014, peak_time_i = 16'h0000, meas_i, disp_val_o;
	thr_omode_t out_mode_i = OUT_ONE;
	thr_crit_t critical_state_action_i = CRIT_HOLD;
	thr_disp_t disp_sel_o;
	logic over_range_i, under_range_i, dp_flash_o, relay_o, led_o, edit_req_o, edit_idx_o;
	int miscompares = 0, checked = 0, ecnt = 0;
	// Ordinary then critical output cases, applied in order since hysteresis keeps history
	thr_row_t rows [13] = '{'{OUT_ONE, 1, CRIT_HOLD, 16'h0000, 16'h0078, 1, 1}, '{OUT_ONE, 1, CRIT_HOLD, 16'h0000, 16'h005f, 0, 1},
		'{OUT_ONE, 1, CRIT_HOLD, 16'h0000, 16'h0050, 1, 0}, '{OUT_ONE, 0, CRIT_HOLD, 16'h0000, 16'h0050, 1, 1},
		'{OUT_TWO, 1, CRIT_HOLD, 16'h00c8, 16'h0096, 1, 1}, '{OUT_TWO, 1, CRIT_HOLD, 16'h0014, 16'h003c, 1, 1},
		'{OUT_TWO, 0, CRIT_HOLD, 16'h0014, 16'h003c, 1, 0}, '{OUT_TWO, 0, CRIT_HOLD, 16'h0014, 16'h0096, 1, 1},
		'{OUT_UNUSED, 0, CRIT_HOLD, 16'h0014, 16'h0096, 1, 0}, '{OUT_ONE, 1, CRIT_HOLD, 16'h0000, 16'h0096, 1, 1},
		'{OUT_ONE, 1, CRIT_HOLD, 16'h0000, 16'hfc18, 1, 1}, '{OUT_ONE, 1, CRIT_OFF, 16'h0000, 16'h07d0, 1, 0},
		'{OUT_ONE, 1, CRIT_ON, 16'h0000, 16'hfc18, 0, 1}};
	////////////////////////////////////////
	thr_src #(.HI_LIM(HI_LIM), .LO_LIM(LO_LIM)) u_src (.val_i(val), .meas_o(meas_i), .over_range_o(over_range_i),
		.under_range_o(under_range_i));
	// Short tick keeps every timer brief
	thr_top #(.TICK_CYC(10), .FW_ID(FW)) dut (.sys_clk_i, .rst_n_i, .meas_i, .over_range_i, .under_range_i,
		.key_up_i(keys[0]), .key_dn_i(keys[1]), .key_ent_i(keys[2]), .key_esc_i(keys[3]), .out_mode_i, .act_i,
		.first_threshold_i, .second_threshold_i, .hysteresis_width_i, .on_delay_i, .off_delay_i, .unit_min_i,
		.critical_state_action_i, .relay_fit_i, .min_peak_swing_i, .peak_time_i, .hold_zero_i, .src_peak_i,
		.free_access_i, .disp_sel_o, .disp_val_o, .dp_flash_o, .relay_o, .led_o, .edit_req_o, .edit_idx_o);
	////////////////////////////////////////
	initial
	begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	// Counts edit pulses, which stand one cycle only
	always @(posedge sys_clk_i)
		if (edit_req_o === 1'b1)
			ecnt <= ecnt + 1;
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : cyc
	task automatic complete_run;
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// A key is held two cycles, then released long enough to land
	task automatic press(input int k);
		keys[k] = 1'b1;
		cyc(2);
		keys[k] = 1'b0;
		cyc(4);
	endtask : press
	task automatic tmo(input int n, input int lim);
		if (n >= lim)
		begin
			miscompares++;
			complete_run();
		end
	endtask : tmo
	////////////////////////////////////////
	initial
	begin
		int n;
		int fl;
		thr_disp_t ed;
		cyc(8);
		chk(16'(disp_sel_o), 16'(DISP_ID));
		rst_n_i = 1'b1;
		cyc(1);
		chk(disp_val_o, FW);
		for (n = 0; n < 300 && disp_sel_o === DISP_ID; n++) cyc(1);
		tmo(n, 300);
		chk(16'(n >= 190), 16'h0001);
		foreach (rows[i])
		begin
			out_mode_i = rows[i].m;
			act_i = rows[i].a;
			critical_state_action_i = rows[i].c;
			second_threshold_i = rows[i].t2;
			val = rows[i].v;
			relay_fit_i = rows[i].f;
			cyc(6);
			ed = ($signed(val) > HI_LIM) ? DISP_OVER : ($signed(val) < LO_LIM) ? DISP_UNDER : DISP_VALUE;
			chk(16'(led_o), 16'(rows[i].led));
			chk(16'(relay_o), 16'(rows[i].led & rows[i].f));
			chk(16'(disp_sel_o), 16'(ed));
		end
		// On-delay of two seconds, interrupted then completed
		critical_state_action_i = CRIT_HOLD;
		val = 16'h0050;
		cyc(6);
		on_delay_i = 16'h0002;
		val = 16'h0078;
		cyc(90);
		val = 16'h0050;
		cyc(150);
		chk(16'(led_o), 16'h0000);
		val = 16'h0078;
		for (n = 0; n < 300 && led_o !== 1'b1; n++) cyc(1);
		tmo(n, 300);
		chk(16'(n >= 100 && n <= 210), 16'h0001);
		on_delay_i = 16'h0000;
		val = 16'h0032;
		cyc(3);
		// Peak shown 15 ticks; a small dip is no peak, a newer one restarts
		peak_time_i = 16'h000f;
		val = 16'h0064;
		cyc(3);
		val = 16'h0055;
		cyc(3);
		chk(16'(disp_sel_o), 16'(DISP_VALUE));
		val = 16'h004f;
		cyc(3);
		chk(16'(disp_sel_o), 16'(DISP_PEAK));
		chk(disp_val_o, 16'h0064);
		cyc(100);
		val = 16'h0082;
		cyc(3);
		val = 16'h0069;
		cyc(3);
		chk(disp_val_o, 16'h0082);
		fl = 0;
		for (n = 0; n < 300 && disp_sel_o === DISP_PEAK; n++)
		begin
			fl += int'(dp_flash_o === 1'b1);
			cyc(1);
		end
		tmo(n, 300);
		chk(16'(n >= 130 && n <= 160), 16'h0001);
		chk(16'(disp_sel_o), 16'(DISP_VALUE));
		chk(16'(fl > 0), 16'h0001);
		// Zero time holds until escape; comparison may use the peak
		peak_time_i = 16'h0000;
		hold_zero_i = 1'b1;
		val = 16'h0032;
		cyc(3);
		val = 16'h0082;
		cyc(3);
		val = 16'h0046;
		cyc(250);
		chk(16'(disp_sel_o), 16'(DISP_PEAK));
		src_peak_i = 1'b1;
		cyc(6);
		chk(16'(led_o), 16'h0001);
		src_peak_i = 1'b0;
		cyc(6);
		chk(16'(led_o), 16'h0000);
		press(3);
		chk(16'(disp_sel_o), 16'(DISP_VALUE));
		hold_zero_i = 1'b0;
		val = 16'h0082;
		cyc(3);
		val = 16'h0046;
		cyc(3);
		chk(16'(disp_sel_o), 16'(DISP_VALUE));
		// Quick view, edit request, timeout; enter outside is refused
		press(0);
		chk(16'(disp_sel_o === DISP_QNAME || disp_sel_o === DISP_QVAL), 16'h0001);
		press(2);
		chk(16'(ecnt), 16'h0001);
		chk(16'(edit_idx_o), 16'h0000);
		for (n = 0; n < 700 && disp_sel_o !== DISP_VALUE; n++) cyc(1);
		tmo(n, 700);
		chk(16'(n >= 400), 16'h0001);
		press(2);
		chk(16'(ecnt), 16'h0001);
		// Reset in mid-run
		rst_n_i = 1'b0;
		cyc(2);
		chk(16'(led_o), 16'h0000);
		rst_n_i = 1'b1;
		cyc(2);
		chk(16'(disp_sel_o), 16'(DISP_ID));
		complete_run();
	end
endmodule : test_threshold_relay_peak_hold
`default_nettype wire
